// ===== src/adcc_pkg.sv
// adcc_pkg: constants shared by the converter control block
// assumes one system clock; a conversion state is one sys_clk period
package adcc_pkg;

  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 16;

  // register byte addresses
  localparam logic [15:0] OFF_RESULT_C    = 16'hFFB4;
  localparam logic [15:0] OFF_CTRL_STATUS = 16'hFFB8;
  localparam logic [15:0] OFF_TRIG_CTRL   = 16'hFFB9;
  localparam logic [15:0] OFF_INT_STATUS  = 16'hFFBA;
  localparam logic [15:0] OFF_INT_MASK    = 16'hFFBB;
  localparam logic [15:0] OFF_PORT5_MODE  = 16'hFFE1;

  // control/status, trigger control and port mode field positions
  localparam int          CS_END_FLAG     = 7;
  localparam int          CS_IRQ_EN       = 6;
  localparam int          CS_START        = 5;
  localparam int          CS_SCAN         = 4;
  localparam int          CS_SPEED        = 3;
  localparam int          CS_CH_MSB       = 2;
  localparam int          TC_TRIG_EN      = 7;
  localparam int          P5_PIN5_MODE    = 5;

  // interrupt status bits
  localparam int          IS_CONV_DONE    = 0;
  localparam int          IS_TRIG_START   = 1;
  localparam int          IS_W            = 2;

  // reset values; trigger control reads its unused bits as the fixed pattern
  localparam logic [7:0]  TRIG_CTRL_FIXED = 8'h7E;
  localparam logic [7:0]  PORT5_MODE_RST  = 8'h00;
  localparam logic [15:0] RESULT_RST      = 16'h0000;

  // conversion time in states, one state per sys_clk cycle
  localparam int          STATE_CLOCKS    = 1;
  localparam int          CONV_STATES_SLOW = 134;
  localparam int          CONV_STATES_FAST = 70;
  localparam int          CONV_CYC_SLOW   = CONV_STATES_SLOW * STATE_CLOCKS;
  localparam int          CONV_CYC_FAST   = CONV_STATES_FAST * STATE_CLOCKS;
  // two cycles go to taking the start and retiring the result
  localparam logic [7:0]  CONV_LEN_SLOW   = 8'(CONV_CYC_SLOW - 2);
  localparam logic [7:0]  CONV_LEN_FAST   = 8'(CONV_CYC_FAST - 2);

  typedef enum logic {
    ADCC_IDLE = 1'b0,
    ADCC_RUN  = 1'b1
  } adcc_conv_state_t;

endpackage : adcc_pkg

// ===== src/adcc_conv_if.sv
// adcc_conv_if: start/done handshake between control and converter timing
// assumes both ends run on sys_clk
`timescale 1ns/1ps
`default_nettype none

interface adcc_conv_if #(parameter int RES_W = 10);
  logic             start;
  logic             fast;
  logic [RES_W-1:0] sample;
  logic             busy;
  logic             done;
  logic [RES_W-1:0] result;

  modport ctl  (output start, output fast, output sample, input busy, input done,
                input result);
  modport conv (input start, input fast, input sample, output busy, output done,
                output result);
endinterface : adcc_conv_if

`default_nettype wire

// ===== src/adcc_converter.sv
// adcc_converter: paces one conversion and captures the sampled code
// assumes start only while idle; the analog front end holds sample steady
`timescale 1ns/1ps
`default_nettype none

module adcc_converter
  import adcc_pkg::*;
(
  input wire logic   sys_clk,
  input wire logic   resetn,
  adcc_conv_if.conv  cif
);

  adcc_conv_state_t state;
  logic [7:0]       cnt;

  assign cif.busy = (state == ADCC_RUN);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state      <= ADCC_IDLE;
      cnt        <= 8'h00;
      cif.done   <= 1'b0;
      cif.result <= '0;
    end else begin
      cif.done <= 1'b0;
      unique case (state)
        ADCC_IDLE: begin
          if (cif.start) begin
            cnt   <= cif.fast ? CONV_LEN_FAST : CONV_LEN_SLOW;
            state <= ADCC_RUN;
          end
        end
        ADCC_RUN: begin
          if (cnt == 8'h01) begin
            cif.done   <= 1'b1;
            cif.result <= cif.sample;
            state      <= ADCC_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
      endcase
    end
  end

endmodule : adcc_converter

`default_nettype wire

// ===== src/adcc_top.sv
// adcc_top: converter control registers, start sources, flags and interrupt
// assumes a plain register port with one-cycle strobes and synchronous inputs
//
// Functional notes
// - writing start bit one begins conversion
// - single mode clears start bit when done
// - scan bit zero: one channel, one conversion
// - speed bit zero: done within 134 states
// - selector field picks input; zero is input 0
// - trigger enable zero ignores trigger edges
// - trigger control enables external trigger starts
// - result lands in result register C
// - port mode bit zero: pin not trigger
// - end flag sets; clears by write-zero after read
// - irq enable zero blocks conversion end irq; the int_status done bit still raises irq when int_mask bit 0 is set
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module adcc_top
  import adcc_pkg::*;
#(
  parameter int RES_W = 10
)(
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [DATA_W-1:0] bus_wdata,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  output var  logic [DATA_W-1:0] bus_rdata,
  input  wire logic              external_trigger_input,
  input  wire logic [RES_W-1:0]  analog_sample,
  output var  logic [2:0]        analog_channel,
  output var  logic              irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  adcc_conv_if #(.RES_W(RES_W)) cif ();

  logic             conversion_end_flag;
  logic             conversion_end_irq_enable;
  logic             conversion_start_bit;
  logic             scan_mode;
  logic             conversion_speed_select;
  logic             external_trigger_enable;
  logic             end_flag_seen;
  logic             scan_stop;
  logic             trig_prev;
  logic [7:0]       port5_mode;
  logic [15:0]      conversion_result_c;
  logic [IS_W-1:0]  int_status;
  logic [IS_W-1:0]  int_mask;

  logic             wr_cs;
  logic             rd_cs;
  logic             trig_start;
  logic             sw_start;
  logic             scan_restart;
  logic             start_fast;
  logic [IS_W-1:0]  int_events;
  logic [7:0]       cs_value;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction : hit

  assign wr_cs      = bus_wr && hit(bus_addr, OFF_CTRL_STATUS);
  assign rd_cs      = bus_rd && hit(bus_addr, OFF_CTRL_STATUS);
  assign sw_start   = wr_cs && bus_wdata[CS_START] && !conversion_start_bit;
  // falling edge only; inputs are synchronous so one stage of history is enough
  assign trig_start = external_trigger_enable && port5_mode[P5_PIN5_MODE]
                    && trig_prev && !external_trigger_input && !conversion_start_bit;
  assign scan_restart = cif.done && scan_mode && conversion_start_bit && !scan_stop;
  // speed written beside the start bit must govern that same conversion
  assign start_fast = wr_cs ? bus_wdata[CS_SPEED] : conversion_speed_select;
  assign int_events = {trig_start, cif.done};
  assign cs_value   = {conversion_end_flag, conversion_end_irq_enable, conversion_start_bit,
                       scan_mode, conversion_speed_select, analog_channel};

  assign cif.start  = sw_start || trig_start || scan_restart;
  assign cif.fast   = start_fast;
  assign cif.sample = analog_sample;

  adcc_converter u_conv (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .cif     (cif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control/status register

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      conversion_end_irq_enable <= 1'b0;
      scan_mode                 <= 1'b0;
      conversion_speed_select   <= 1'b0;
      analog_channel            <= 3'h0;
    end else if (wr_cs) begin
      conversion_end_irq_enable <= bus_wdata[CS_IRQ_EN];
      scan_mode                 <= bus_wdata[CS_SCAN];
      conversion_speed_select   <= bus_wdata[CS_SPEED];
      analog_channel            <= bus_wdata[CS_CH_MSB:0];
    end
  end

  // no conversion can be aborted, so the bit stays up until done
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      conversion_start_bit <= 1'b0;
    end else if (cif.done && (!scan_mode || scan_stop)) begin
      conversion_start_bit <= 1'b0;
    end else if (sw_start || trig_start) begin
      conversion_start_bit <= 1'b1;
    end
  end

  // a zero written while busy is remembered; the bit keeps reading one until done
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      scan_stop <= 1'b0;
    end else if (!conversion_start_bit || (cif.done && (!scan_mode || scan_stop))) begin
      scan_stop <= 1'b0;
    end else if (wr_cs && !bus_wdata[CS_START]) begin
      scan_stop <= 1'b1;
    end
  end

  // set wins over the clear written in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      conversion_end_flag <= 1'b0;
      end_flag_seen       <= 1'b0;
    end else if (cif.done && !scan_mode) begin
      conversion_end_flag <= 1'b1;
    end else if (wr_cs && !bus_wdata[CS_END_FLAG] && end_flag_seen) begin
      conversion_end_flag <= 1'b0;
      end_flag_seen       <= 1'b0;
    end else if (rd_cs && conversion_end_flag) begin
      end_flag_seen       <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger control, port mode, result

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      external_trigger_enable <= 1'b0;
      port5_mode              <= PORT5_MODE_RST;
      // pin idles high; a low history would miss an edge right after reset
      trig_prev               <= 1'b1;
    end else begin
      trig_prev <= external_trigger_input;
      if (bus_wr && hit(bus_addr, OFF_TRIG_CTRL)) begin
        external_trigger_enable <= bus_wdata[TC_TRIG_EN];
      end
      if (bus_wr && hit(bus_addr, OFF_PORT5_MODE)) begin
        port5_mode <= bus_wdata[7:0];
      end
    end
  end

  // code is left-justified in the 16-bit result
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      conversion_result_c <= RESULT_RST;
    end else if (cif.done) begin
      conversion_result_c <= {cif.result, (16 - RES_W)'(0)};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, mask, output

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      int_status <= '0;
      int_mask   <= '0;
    end else begin
      if (bus_wr && hit(bus_addr, OFF_INT_STATUS)) begin
        int_status <= (int_status & ~bus_wdata[IS_W-1:0]) | int_events;
      end else begin
        int_status <= int_status | int_events;
      end
      if (bus_wr && hit(bus_addr, OFF_INT_MASK)) begin
        int_mask <= bus_wdata[IS_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (conversion_end_flag && conversion_end_irq_enable)
           || ((int_status & int_mask) != '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port; unmapped addresses read zero

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bus_rdata <= '0;
    end else if (!bus_rd) begin
      bus_rdata <= '0;
    end else begin
      unique case (bus_addr)
        OFF_RESULT_C:    bus_rdata <= conversion_result_c;
        OFF_CTRL_STATUS: bus_rdata <= {8'h00, cs_value};
        OFF_TRIG_CTRL:   bus_rdata <= {8'h00, external_trigger_enable,
                                       TRIG_CTRL_FIXED[6:0]};
        OFF_INT_STATUS:  bus_rdata <= {{(DATA_W - IS_W){1'b0}}, int_status};
        OFF_INT_MASK:    bus_rdata <= {{(DATA_W - IS_W){1'b0}}, int_mask};
        OFF_PORT5_MODE:  bus_rdata <= {8'h00, port5_mode};
        default:         bus_rdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_sw_start;
    wr_cs && bus_wdata[CS_START] && !conversion_start_bit;
  endsequence

  sequence s_slow_start;
    cif.start && !cif.fast;
  endsequence

  sequence s_single_done;
    cif.done && !scan_mode;
  endsequence

  chk_sw_start_run: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_sw_start |=> conversion_start_bit && cif.busy)
    else $error("software start did not begin a conversion");

  chk_single_autoclr: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_single_done |=> !conversion_start_bit && conversion_end_flag)
    else $error("single conversion end did not clear start bit");

  chk_single_once: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_single_done ##1 !cif.start |-> !cif.busy [*2])
    else $error("single mode converted again");

  chk_slow_time: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_slow_start |-> ##1 !cif.done [*8] ##125 cif.done)
    else $error("slow conversion length wrong");

  chk_fast_time: assert property (@(posedge sys_clk) disable iff (!resetn)
    cif.start && cif.fast |-> ##1 !cif.done [*8] ##61 cif.done)
    else $error("fast conversion length wrong");

  chk_sel_channel: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_cs |=> analog_channel == $past(bus_wdata[2:0]))
    else $error("input selector not taken from write");

  chk_trig_disabled: assert property (@(posedge sys_clk) disable iff (!resetn)
    !external_trigger_enable && !conversion_start_bit && !wr_cs |=> !conversion_start_bit)
    else $error("conversion started with trigger disabled");

  chk_trig_start: assert property (@(posedge sys_clk) disable iff (!resetn)
    external_trigger_enable && port5_mode[P5_PIN5_MODE] && !conversion_start_bit
    && $fell(external_trigger_input) |=> conversion_start_bit && cif.busy)
    else $error("enabled trigger edge did not start conversion");

  chk_result_store: assert property (@(posedge sys_clk) disable iff (!resetn)
    cif.done |=> conversion_result_c[15 -: RES_W] == $past(cif.result))
    else $error("result not stored in result register");

  chk_result_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    !cif.done |=> $stable(conversion_result_c))
    else $error("result register changed without a conversion end");

  chk_pin_is_port: assert property (@(posedge sys_clk) disable iff (!resetn)
    !port5_mode[P5_PIN5_MODE] && !conversion_start_bit && !wr_cs |=> !conversion_start_bit)
    else $error("pin used as trigger while in port mode");

  chk_flag_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    conversion_end_flag && !end_flag_seen |=> conversion_end_flag)
    else $error("end flag cleared without prior read");

  chk_irq_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!conversion_end_irq_enable || !conversion_end_flag)
    && ((int_status & int_mask) == '0) |=> !irq)
    else $error("interrupt raised while disabled");

  chk_end_irq: assert property (@(posedge sys_clk) disable iff (!resetn)
    conversion_end_flag && conversion_end_irq_enable |=> irq)
    else $error("enabled end flag raised no interrupt");

  chk_busy_readback: assert property (@(posedge sys_clk) disable iff (!resetn)
    cif.busy |-> conversion_start_bit)
    else $error("start bit low during conversion");

  chk_start_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
    conversion_start_bit && !cif.done |=> conversion_start_bit)
    else $error("start bit dropped before conversion end");

  chk_scan_again: assert property (@(posedge sys_clk) disable iff (!resetn)
    cif.done && scan_mode && conversion_start_bit && !scan_stop |=> cif.busy
    && conversion_start_bit)
    else $error("scan mode did not convert again");

  chk_scan_stop: assert property (@(posedge sys_clk) disable iff (!resetn)
    cif.done && scan_stop |=> !conversion_start_bit && !cif.busy)
    else $error("scan stop did not end after current conversion");

endmodule : adcc_top

`default_nettype wire

// ===== tb/adcc_front_model.sv
// adcc_front_model: analog front end and trigger source facing adcc_top
// assumes the bench picks the code level and requests trigger pulses
`timescale 1ns/1ps
`default_nettype none

module adcc_front_model
  import adcc_pkg::*;
#(
  parameter int RES_W = 10
)(
  input  wire logic             sys_clk,
  input  wire logic [2:0]       analog_channel,
  input  wire logic [RES_W-1:0] level,
  input  wire logic             fire,
  output var  logic [RES_W-1:0] analog_sample,
  output var  logic             external_trigger_input
);
  logic [2:0] low_cnt = 3'h0;

  // code depends on channel so a wrong selector shows in the result
  always_comb analog_sample = level ^ RES_W'(analog_channel);

  ////////////////////////////////////////////////////////////////
  // pulse held low four cycles; idle high like a pulled-up pin
  always_ff @(posedge sys_clk) begin
    if (fire) low_cnt <= 3'h4;
    else if (low_cnt != 3'h0) low_cnt <= low_cnt - 3'h1;
  end
  always_comb external_trigger_input = (low_cnt == 3'h0);
endmodule : adcc_front_model

`default_nettype wire

// ===== tb/tb_top.sv
// tb_top: self-checking bench for adcc_top with random codes and channels
// assumes adcc_front_model on the analog side, register port from here
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import adcc_pkg::*;
  localparam int RES_W = 10;
  logic              sys_clk   = 1'b0;
  logic              resetn    = 1'b0;
  logic [15:0]       bus_addr  = 16'h0000;
  logic [15:0]       bus_wdata = 16'h0000;
  logic              bus_wr    = 1'b0;
  logic              bus_rd    = 1'b0;
  logic              fire      = 1'b0;
  logic [RES_W-1:0]  lv        = 10'h000;
  logic [15:0]       bus_rdata;
  logic [RES_W-1:0]  analog_sample;
  logic [2:0]        analog_channel;
  logic              irq;
  logic              trig;
  logic [15:0]       rv;
  logic [31:0]       rng = 32'd76521;
  logic [2:0]        ch;
  logic              a;
  logic              b;
  int unsigned       n_errors = 0;
  int unsigned       n_tests = 0;
  int unsigned       cyc = 0;

  always #12.5 sys_clk = ~sys_clk;

  adcc_top #(.RES_W(RES_W)) u_adcc_top (.sys_clk(sys_clk), .resetn(resetn),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .external_trigger_input(trig),
    .analog_sample(analog_sample), .analog_channel(analog_channel), .irq(irq));
  adcc_front_model #(.RES_W(RES_W)) u_adcc_front_model (.sys_clk(sys_clk),
    .analog_channel(analog_channel), .level(lv), .fire(fire),
    .analog_sample(analog_sample), .external_trigger_input(trig));

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  // left-justified code the front end gives for a channel
  function automatic logic [15:0] exp_res(input logic [9:0] l, input logic [2:0] c);
    return {l ^ {7'h00, c}, 6'h00};
  endfunction : exp_res

  task automatic wr(input logic [15:0] ad, input logic [15:0] d);
    @(posedge sys_clk);
    bus_wr <= 1'b1;
    bus_addr <= ad;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] ad);
    @(posedge sys_clk);
    bus_rd <= 1'b1;
    bus_addr <= ad;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 rv = bus_rdata;
  endtask : rd
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // ceiling well above the roughly 1700 cycles the tests need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(OFF_CTRL_STATUS); chk("cs reset", 16'h0000, rv);
    rd(OFF_TRIG_CTRL); chk("tc reset", {8'h00, TRIG_CTRL_FIXED}, rv);
    rd(OFF_RESULT_C); chk("res reset", RESULT_RST, rv);
    rd(OFF_PORT5_MODE); chk("p5 reset", {8'h00, PORT5_MODE_RST}, rv);
    wr(16'h1234, 16'hFFFF);
    rd(16'h1234); chk("unmapped", 16'h0000, rv);
    $display("test reset done");
    // single mode: both speeds, irq enable on and off
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      ch = rng[2:0];
      lv <= rng[12:3];
      a = i[0];
      b = i[1];
      wr(OFF_CTRL_STATUS, {9'h000, b, 2'b10, a, ch});
      rd(OFF_CTRL_STATUS); chk("busy", {9'h000, b, 2'b10, a, ch}, rv);
      chk("chan", {13'h0000, ch}, {13'h0000, analog_channel});
      repeat (a ? 64 : 128) @(posedge sys_clk);
      rd(OFF_CTRL_STATUS); chk("still busy", {9'h000, b, 2'b10, a, ch}, rv);
      repeat (4) @(posedge sys_clk);
      chk("irq", {15'h0000, b}, {15'h0000, irq});
      rd(OFF_RESULT_C); chk("result", exp_res(lv, ch), rv);
      wr(OFF_RESULT_C, 16'hFFFF);
      rd(OFF_RESULT_C); chk("result ro", exp_res(lv, ch), rv);
      wr(OFF_CTRL_STATUS, {9'h000, b, 2'b00, a, ch});
      rd(OFF_CTRL_STATUS); chk("done", {8'h00, 1'b1, b, 2'b00, a, ch}, rv);
      wr(OFF_CTRL_STATUS, {9'h000, b, 2'b00, a, ch});
      rd(OFF_CTRL_STATUS); chk("flag clr", {9'h000, b, 2'b00, a, ch}, rv);
      repeat (2) @(posedge sys_clk);
      chk("irq clr", 16'h0000, {15'h0000, irq});
      wr(OFF_INT_STATUS, 16'h0003);
    end
    $display("test single done");
    // trigger: enable and pin function in all four combinations
    for (int j = 0; j < 4; j++) begin
      a = j[0];
      b = j[1];
      wr(OFF_CTRL_STATUS, 16'h0000);
      wr(OFF_TRIG_CTRL, {8'h00, a, 7'h00});
      rd(OFF_TRIG_CTRL); chk("tc", {8'h00, a, 6'h3F, 1'b0}, rv);
      wr(OFF_PORT5_MODE, {10'h000, b, 5'h00});
      @(posedge sys_clk);
      fire <= 1'b1;
      @(posedge sys_clk);
      fire <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rd(OFF_CTRL_STATUS); chk("trig start", {10'h000, a & b, 5'h00}, rv);
      rd(OFF_INT_STATUS); chk("trig stat", {14'h0000, a & b, 1'b0}, rv);
      wr(OFF_INT_MASK, 16'h0002);
      repeat (2) @(posedge sys_clk);
      chk("irq mask", {15'h0000, a & b}, {15'h0000, irq});
      wr(OFF_INT_STATUS, 16'h0002);
      repeat (2) @(posedge sys_clk);
      chk("irq w1c", 16'h0000, {15'h0000, irq});
      wr(OFF_INT_MASK, 16'h0000);
      repeat (140) @(posedge sys_clk);
      rd(OFF_CTRL_STATUS);
      wr(OFF_CTRL_STATUS, 16'h0000);
      wr(OFF_INT_STATUS, 16'h0003);
    end
    $display("test trigger done");
    // scan mode keeps converting and never raises the end flag
    rng = xs(rng);
    ch = rng[2:0];
    lv <= rng[12:3];
    wr(OFF_CTRL_STATUS, {10'h000, 2'b11, 1'b0, ch});
    repeat (300) @(posedge sys_clk);
    rd(OFF_CTRL_STATUS); chk("scan run", {10'h000, 2'b11, 1'b0, ch}, rv);
    rd(OFF_RESULT_C); chk("scan res", exp_res(lv, ch), rv);
    rd(OFF_INT_STATUS); chk("scan stat", 16'h0001, rv);
    wr(OFF_CTRL_STATUS, {10'h000, 2'b01, 1'b0, ch});
    rd(OFF_CTRL_STATUS); chk("scan finishing", {10'h000, 2'b11, 1'b0, ch}, rv);
    repeat (140) @(posedge sys_clk);
    rd(OFF_CTRL_STATUS); chk("scan stop", {10'h000, 2'b01, 1'b0, ch}, rv);
    $display("test scan done");
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
